// ===== common/alu_pkg.sv
// package: operation codes, field layouts, flag positions and reset values for the datapath
package alu_pkg;

    localparam int DATA_W     = 8;
    localparam int PTR_W      = 16;
    localparam int IMM6_W     = 6;
    localparam int FADDR_W    = 7;
    localparam int NIBBLE_MSB = 3;
    localparam int SIGN_BIT   = 7;

    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [PTR_W-1:0]  PTR_RESET = 16'h0000;
    localparam logic [FADDR_W-1:0] INDIRECT_ADDR0 = 7'h00;
    localparam logic [FADDR_W-1:0] INDIRECT_ADDR1 = 7'h01;
    localparam int EXTRA_CYCLES = 1;

    typedef enum logic [3:0] {
        OP_NONE                       = 4'h0,
        OP_POINTER_ADD_IMMEDIATE      = 4'h1,
        OP_AND_IMMEDIATE              = 4'h2,
        OP_ADD_IMMEDIATE              = 4'h3,
        OP_AND_WITH_REGISTER          = 4'h4,
        OP_ADD_WITH_REGISTER          = 4'h5,
        OP_ARITH_RIGHT_SHIFT          = 4'h6,
        OP_ADD_REGISTER_WITH_CARRY_IN = 4'h7
    } alu_op_e;

    // one instruction from the decoder
    typedef struct packed {
        alu_op_e              op;
        logic [DATA_W-1:0]    imm;
        logic                 ptr_sel;
        logic [FADDR_W-1:0]   faddr;
        logic                 dest_reg;
    } alu_cmd_s;

    // status flags
    typedef struct packed {
        logic zero;
        logic nibble_overflow_bit;
        logic carry;
    } alu_flags_s;

    localparam alu_flags_s FLAGS_RESET = '{zero: 1'b0, nibble_overflow_bit: 1'b0, carry: 1'b0};

endpackage

// ===== core/alu_adder8.sv
// 8-bit adder with carry-in, nibble carry and carry out
`timescale 1ns/1ps
module alu_adder8
    import alu_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    input  wire logic [WIDTH-1:0] i_a,
    input  wire logic [WIDTH-1:0] i_b,
    input  wire logic             i_cin,
    output logic      [WIDTH-1:0] o_sum,
    output logic                  o_nibble_cout,
    output logic                  o_cout
);
    logic [WIDTH:0]        full_sum;
    logic [NIBBLE_MSB+1:0] low_sum;

    assign full_sum      = {1'b0, i_a} + {1'b0, i_b} + {{WIDTH{1'b0}}, i_cin};
    assign low_sum       = {1'b0, i_a[NIBBLE_MSB:0]} + {1'b0, i_b[NIBBLE_MSB:0]}
                           + {{(NIBBLE_MSB+1){1'b0}}, i_cin};
    assign o_sum         = full_sum[WIDTH-1:0];
    assign o_cout        = full_sum[WIDTH];
    assign o_nibble_cout = low_sum[NIBBLE_MSB+1];
endmodule

// ===== core/alu_exec.sv
// execution datapath: pointer add, literal and register arithmetic, shift, flags
//
// Summary of operation
// - add signed 6-bit immediate to selected pointer
// - pointer sum wraps modulo 16 bits
// - and immediate into accumulator, zero only
// - add immediate into accumulator, all flags
// - and accumulator with register, zero only
// - destination bit picks accumulator or register
// - add accumulator and register, all flags
// - arithmetic shift right, bit0 to carry
// - add accumulator, register and carry
// - indirect register with pointer msb stalls
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module alu_exec
    import alu_pkg::*;
(
    input  wire logic               I_MCLK,
    input  wire logic               I_RST,
    input  wire logic               I_CMD_VALID,
    input  wire alu_cmd_s           I_CMD,
    input  wire logic [DATA_W-1:0]  I_FREG_RDATA,
    output logic                    O_CMD_READY,
    output logic                    O_DONE,
    output logic                    O_FREG_WE,
    output logic      [FADDR_W-1:0] O_FREG_ADDR,
    output logic      [DATA_W-1:0]  O_FREG_WDATA,
    output logic      [DATA_W-1:0]  O_ACC,
    output alu_flags_s              O_FLAGS,
    output logic      [PTR_W-1:0]   O_PTR0,
    output logic      [PTR_W-1:0]   O_PTR1
);
    // ==========================================================
    // state
    // ==========================================================
    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_STALL = 2'b10
    } exec_state_e;

    exec_state_e       state_r;
    exec_state_e       state_nxt;
    alu_cmd_s          held_r;
    logic [DATA_W-1:0] held_data_r;
    logic [DATA_W-1:0] acc_r;
    alu_flags_s        flags_r;
    logic [PTR_W-1:0]  ptr0_r;
    logic [PTR_W-1:0]  ptr1_r;
    logic              done_r;
    logic              freg_we_r;
    logic [FADDR_W-1:0] freg_addr_r;
    logic [DATA_W-1:0] freg_wdata_r;

    // ==========================================================
    // decode
    // ==========================================================
    wire logic is_reg_op  = (I_CMD.op == OP_AND_WITH_REGISTER)
                          | (I_CMD.op == OP_ADD_WITH_REGISTER)
                          | (I_CMD.op == OP_ARITH_RIGHT_SHIFT)
                          | (I_CMD.op == OP_ADD_REGISTER_WITH_CARRY_IN);
    wire logic hit_ind0   = (I_CMD.faddr == INDIRECT_ADDR0) & ptr0_r[PTR_W-1];
    wire logic hit_ind1   = (I_CMD.faddr == INDIRECT_ADDR1) & ptr1_r[PTR_W-1];
    wire logic need_stall = I_CMD_VALID & is_reg_op & (hit_ind0 | hit_ind1);
    wire logic take_now   = I_CMD_VALID & (state_r == ST_RUN) & ~need_stall;
    wire logic run_held   = (state_r == ST_STALL);
    wire logic exec_en    = take_now | run_held;

    wire alu_cmd_s          cmd   = run_held ? held_r : I_CMD;
    wire logic [DATA_W-1:0] fdata = run_held ? held_data_r : I_FREG_RDATA;

    // ==========================================================
    // arithmetic
    // ==========================================================
    wire logic is_imm     = (cmd.op == OP_ADD_IMMEDIATE);
    wire logic use_cin    = (cmd.op == OP_ADD_REGISTER_WITH_CARRY_IN);
    wire logic [DATA_W-1:0] add_b = is_imm ? cmd.imm : fdata;
    logic [DATA_W-1:0] add_sum;
    logic              add_dc;
    logic              add_c;

    alu_adder8 #(.WIDTH(DATA_W)) u_adder (
        .i_a           (acc_r),
        .i_b           (add_b),
        .i_cin         (use_cin & flags_r.carry),
        .o_sum         (add_sum),
        .o_nibble_cout (add_dc),
        .o_cout        (add_c)
    );

    wire logic [PTR_W-1:0] imm_ext = {{(PTR_W-IMM6_W){cmd.imm[IMM6_W-1]}},
                                      cmd.imm[IMM6_W-1:0]};
    wire logic [PTR_W-1:0] ptr_cur = cmd.ptr_sel ? ptr1_r : ptr0_r;
    wire logic [PTR_W-1:0] ptr_sum = ptr_cur + imm_ext;

    wire logic [DATA_W-1:0] shr_res = {fdata[SIGN_BIT], fdata[DATA_W-1:1]};

    // result, flag update mask, and destination
    logic [DATA_W-1:0] res;
    alu_flags_s        fnew;
    logic              upd_z;
    logic              upd_c;
    logic              upd_dc;
    logic              to_reg;

    always_comb begin
        res    = add_sum;
        fnew   = flags_r;
        upd_z  = 1'b0;
        upd_c  = 1'b0;
        upd_dc = 1'b0;
        to_reg = 1'b0;
        case (cmd.op)
            OP_AND_IMMEDIATE: begin
                res   = acc_r & cmd.imm;
                upd_z = 1'b1;
            end
            OP_ADD_IMMEDIATE: begin
                upd_z  = 1'b1;
                upd_c  = 1'b1;
                upd_dc = 1'b1;
            end
            OP_AND_WITH_REGISTER: begin
                res    = acc_r & fdata;
                upd_z  = 1'b1;
                to_reg = cmd.dest_reg;
            end
            OP_ADD_WITH_REGISTER, OP_ADD_REGISTER_WITH_CARRY_IN: begin
                upd_z  = 1'b1;
                upd_c  = 1'b1;
                upd_dc = 1'b1;
                to_reg = cmd.dest_reg;
            end
            OP_ARITH_RIGHT_SHIFT: begin
                res    = shr_res;
                upd_z  = 1'b1;
                upd_c  = 1'b1;
                to_reg = cmd.dest_reg;
            end
            default: begin
                res = acc_r;
            end
        endcase
        if (upd_z) begin
            fnew.zero = (res == '0);
        end
        if (upd_c) begin
            fnew.carry = (cmd.op == OP_ARITH_RIGHT_SHIFT) ? fdata[0] : add_c;
        end
        if (upd_dc) begin
            fnew.nibble_overflow_bit = add_dc;
        end
    end

    wire logic writes_acc = (cmd.op != OP_NONE) & (cmd.op != OP_POINTER_ADD_IMMEDIATE)
                          & ~to_reg;

    // ==========================================================
    // sequencing
    // ==========================================================
    always_comb begin
        case (state_r)
            ST_RUN:   state_nxt = need_stall ? ST_STALL : ST_RUN;
            ST_STALL: state_nxt = ST_RUN;
            default:  state_nxt = ST_RUN;
        endcase
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            state_r     <= ST_RUN;
            held_r      <= '0;
            held_data_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (need_stall & (state_r == ST_RUN)) begin
                held_r      <= I_CMD;
                held_data_r <= I_FREG_RDATA;
            end
        end
    end

    // ==========================================================
    // architectural state
    // ==========================================================
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            acc_r   <= ACC_RESET;
            flags_r <= FLAGS_RESET;
            ptr0_r  <= PTR_RESET;
            ptr1_r  <= PTR_RESET;
        end else if (exec_en) begin
            flags_r <= fnew;
            if (writes_acc) begin
                acc_r <= res;
            end
            if ((cmd.op == OP_POINTER_ADD_IMMEDIATE) & ~cmd.ptr_sel) begin
                ptr0_r <= ptr_sum;
            end
            if ((cmd.op == OP_POINTER_ADD_IMMEDIATE) & cmd.ptr_sel) begin
                ptr1_r <= ptr_sum;
            end
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            done_r       <= 1'b0;
            freg_we_r    <= 1'b0;
            freg_addr_r  <= '0;
            freg_wdata_r <= '0;
        end else begin
            done_r       <= exec_en & (cmd.op != OP_NONE);
            freg_we_r    <= exec_en & to_reg;
            freg_addr_r  <= cmd.faddr;
            freg_wdata_r <= res;
        end
    end

    // ==========================================================
    // outputs
    // ==========================================================
    assign O_CMD_READY  = (state_r == ST_RUN);
    assign O_DONE       = done_r;
    assign O_FREG_WE    = freg_we_r;
    assign O_FREG_ADDR  = freg_addr_r;
    assign O_FREG_WDATA = freg_wdata_r;
    assign O_ACC        = acc_r;
    assign O_FLAGS      = flags_r;
    assign O_PTR0       = ptr0_r;
    assign O_PTR1       = ptr1_r;

    // ==========================================================
    // checks
    // ==========================================================
    ptr_flags_keep_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (exec_en && cmd.op == OP_POINTER_ADD_IMMEDIATE) |=> $stable(flags_r))
        else $error("pointer add changed flags");

    ptr_wrap_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (exec_en && cmd.op == OP_POINTER_ADD_IMMEDIATE && !cmd.ptr_sel)
        |=> ptr0_r == 16'($past(ptr0_r) + $past(imm_ext)))
        else $error("pointer sum wrong");

    and_imm_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (take_now && I_CMD.op == OP_AND_IMMEDIATE)
        |=> acc_r == ($past(acc_r) & $past(I_CMD.imm)) && flags_r.carry == $past(flags_r.carry))
        else $error("and immediate wrong");

    add_imm_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (take_now && I_CMD.op == OP_ADD_IMMEDIATE)
        |=> {flags_r.carry, acc_r} == {1'b0, $past(acc_r)} + {1'b0, $past(I_CMD.imm)})
        else $error("add immediate wrong");

    and_reg_zero_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (take_now && I_CMD.op == OP_AND_WITH_REGISTER)
        |=> flags_r.zero == (($past(acc_r) & $past(I_FREG_RDATA)) == 8'h00))
        else $error("and register zero flag wrong");

    dest_route_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (exec_en && to_reg) |=> O_FREG_WE && $stable(acc_r))
        else $error("register destination not honoured");

    stall_one_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (need_stall && state_r == ST_RUN) |=> !O_CMD_READY ##1 O_CMD_READY && O_DONE)
        else $error("indirect stall length wrong");

    shift_carry_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (take_now && I_CMD.op == OP_ARITH_RIGHT_SHIFT)
        |=> flags_r.carry == $past(I_FREG_RDATA[0]))
        else $error("shift carry wrong");

    add_carry_in_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (take_now && I_CMD.op == OP_ADD_REGISTER_WITH_CARRY_IN && !I_CMD.dest_reg)
        |=> acc_r == 8'($past(acc_r) + $past(I_FREG_RDATA) + 8'($past(flags_r.carry))))
        else $error("add with carry wrong");

endmodule

// ===== tb/data_mem.sv
// data memory model answering the datapath's register reads and writes
`timescale 1ns/1ps
module data_mem
    import alu_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic [FADDR_W-1:0] i_raddr,
    input  wire logic               i_we,
    input  wire logic [FADDR_W-1:0] i_waddr,
    input  wire logic [DATA_W-1:0]  i_wdata,
    output logic      [DATA_W-1:0]  o_rdata
);
    logic [DATA_W-1:0] mem [0:127];
    assign o_rdata = mem[i_raddr];
    // plain always: the bench also preloads and patches this array directly
    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end
endmodule

// ===== tb/tb.sv
// self-checking bench for the execution datapath
`timescale 1ns/1ps
module tb;
    import alu_pkg::*;
    logic               mclk;
    logic               rst;
    logic               cmd_valid;
    alu_cmd_s           cmd;
    logic [DATA_W-1:0]  rdata;
    logic               ready;
    logic               done;
    logic               we;
    logic [FADDR_W-1:0] waddr;
    logic [DATA_W-1:0]  wdata;
    logic [DATA_W-1:0]  acc_o;
    alu_flags_s         flags_o;
    logic [PTR_W-1:0]   ptr0;
    logic [PTR_W-1:0]   ptr1;
    logic [DATA_W-1:0]  acc;
    alu_flags_s         fl;
    logic [PTR_W-1:0]   p0;
    logic [PTR_W-1:0]   p1;
    int                 num_errors;
    int                 tests_run;
    int                 cycles;

    alu_exec u_dut (.I_MCLK(mclk), .I_RST(rst), .I_CMD_VALID(cmd_valid), .I_CMD(cmd),
        .I_FREG_RDATA(rdata), .O_CMD_READY(ready), .O_DONE(done), .O_FREG_WE(we),
        .O_FREG_ADDR(waddr), .O_FREG_WDATA(wdata), .O_ACC(acc_o), .O_FLAGS(flags_o),
        .O_PTR0(ptr0), .O_PTR1(ptr1));
    data_mem u_mem (.i_clk(mclk), .i_raddr(cmd.faddr), .i_we(we), .i_waddr(waddr),
        .i_wdata(wdata), .o_rdata(rdata));

    // ========================================
    // clock and timeout
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end

    // ========================================
    // shared tasks
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic exec(input alu_op_e op, input logic [7:0] imm, input logic ps,
                        input logic [6:0] fa, input logic d);
        logic [7:0] fv, b, r, me;
        logic [8:0] s;
        logic       cin, rop, stall;
        int         n;
        fv = u_mem.mem[fa];
        rop = (op >= OP_AND_WITH_REGISTER);
        stall = rop && ((fa == 7'h00 && p0[15]) || (fa == 7'h01 && p1[15]));
        b = rop ? fv : imm;
        cin = (op == OP_ADD_REGISTER_WITH_CARRY_IN) ? fl.carry : 1'b0;
        s = {1'b0, acc} + {1'b0, b} + {8'h00, cin};
        r = s[7:0];
        case (op)
            OP_POINTER_ADD_IMMEDIATE: begin
                if (ps) begin
                    p1 = p1 + {{10{imm[5]}}, imm[5:0]};
                end else begin
                    p0 = p0 + {{10{imm[5]}}, imm[5:0]};
                end
            end
            OP_AND_IMMEDIATE, OP_AND_WITH_REGISTER: r = acc & b;
            OP_ARITH_RIGHT_SHIFT: begin
                r = {fv[7], fv[7:1]};
                fl.carry = fv[0];
            end
            default: begin
                fl.carry = s[8];
                fl.nibble_overflow_bit = ({1'b0, acc[3:0]} + {1'b0, b[3:0]} + {4'h0, cin}) > 5'h0f;
            end
        endcase
        me = (rop && d) ? r : fv;
        if (op != OP_POINTER_ADD_IMMEDIATE) begin
            fl.zero = (r == 8'h00);
            if (!(rop && d)) begin
                acc = r;
            end
        end
        @(posedge mclk);
        cmd <= '{op: op, imm: imm, ptr_sel: ps, faddr: fa, dest_reg: d};
        cmd_valid <= 1'b1;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        #1;
        chk("ready", 16'(!stall), 16'(ready));
        n = 0;
        while (done !== 1'b1 && n < 4) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("extra cycles", 16'(stall), 16'(n));
        @(posedge mclk);
        #1;
        chk("accumulator", 16'(acc), 16'(acc_o));
        chk("flags", 16'(fl), 16'(flags_o));
        chk("pointer0", p0, ptr0);
        chk("pointer1", p1, ptr1);
        chk("file register", 16'(me), 16'(u_mem.mem[fa]));
    endtask

    // ========================================
    // scenarios
    task automatic t_reset();
        chk("ready", 16'h0001, 16'(ready));
        chk("reset accumulator", 16'(ACC_RESET), 16'(acc_o));
        chk("reset flags", 16'(FLAGS_RESET), 16'(flags_o));
        $display("test reset done");
    endtask

    task automatic t_imm();
        exec(OP_ADD_IMMEDIATE, 8'hff, 1'b0, 7'h05, 1'b0);
        exec(OP_ADD_IMMEDIATE, 8'h01, 1'b0, 7'h05, 1'b0);
        exec(OP_AND_IMMEDIATE, 8'hff, 1'b0, 7'h05, 1'b0);
        exec(OP_ADD_IMMEDIATE, 8'h8f, 1'b0, 7'h05, 1'b0);
        exec(OP_AND_IMMEDIATE, 8'h0c, 1'b0, 7'h05, 1'b0);
        exec(OP_ADD_IMMEDIATE, 8'hf4, 1'b0, 7'h05, 1'b0);
        $display("test immediate done");
    endtask

    task automatic t_pointer();
        exec(OP_POINTER_ADD_IMMEDIATE, 8'h20, 1'b0, 7'h05, 1'b0);
        exec(OP_POINTER_ADD_IMMEDIATE, 8'h1f, 1'b0, 7'h05, 1'b0);
        exec(OP_POINTER_ADD_IMMEDIATE, 8'h01, 1'b0, 7'h05, 1'b0);
        exec(OP_POINTER_ADD_IMMEDIATE, 8'h3f, 1'b1, 7'h05, 1'b0);
        $display("test pointer done");
    endtask

    task automatic t_reg();
        exec(OP_ADD_IMMEDIATE, 8'hc4, 1'b0, 7'h05, 1'b0);
        exec(OP_AND_WITH_REGISTER, 8'h00, 1'b0, 7'h0a, 1'b1);
        exec(OP_ADD_WITH_REGISTER, 8'h00, 1'b0, 7'h0b, 1'b0);
        exec(OP_ADD_WITH_REGISTER, 8'h00, 1'b0, 7'h0a, 1'b1);
        exec(OP_AND_WITH_REGISTER, 8'h00, 1'b0, 7'h0c, 1'b0);
        $display("test register done");
    endtask

    task automatic t_shift_carry();
        u_mem.mem[12] = 8'h81;
        u_mem.mem[13] = 8'h01;
        exec(OP_ARITH_RIGHT_SHIFT, 8'h00, 1'b0, 7'h0c, 1'b0);
        exec(OP_ARITH_RIGHT_SHIFT, 8'h00, 1'b0, 7'h0d, 1'b1);
        exec(OP_ADD_REGISTER_WITH_CARRY_IN, 8'h00, 1'b0, 7'h0e, 1'b0);
        exec(OP_ADD_REGISTER_WITH_CARRY_IN, 8'h00, 1'b0, 7'h0b, 1'b1);
        exec(OP_ADD_REGISTER_WITH_CARRY_IN, 8'h00, 1'b0, 7'h0e, 1'b0);
        $display("test shift and carry done");
    endtask

    task automatic t_stall();
        exec(OP_ADD_WITH_REGISTER, 8'h00, 1'b0, 7'h01, 1'b0);
        exec(OP_AND_WITH_REGISTER, 8'h00, 1'b0, 7'h00, 1'b1);
        exec(OP_POINTER_ADD_IMMEDIATE, 8'h20, 1'b0, 7'h05, 1'b0);
        exec(OP_ARITH_RIGHT_SHIFT, 8'h00, 1'b0, 7'h00, 1'b1);
        $display("test stall done");
    endtask

    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        acc = ACC_RESET;
        fl = FLAGS_RESET;
        p0 = PTR_RESET;
        p1 = PTR_RESET;
        for (int i = 0; i < 128; i++) begin
            u_mem.mem[i] = 8'(i * 37 + 3);
        end
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        t_reset();
        t_imm();
        t_pointer();
        t_reg();
        t_shift_carry();
        t_stall();
        conclude();
    end
endmodule
